// file: design/ssp_fifo.sv
// Parameterised valid/ready FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic [WIDTH-1:0] q_r, q_nxt;
   logic             qv_r, qv_nxt;
   logic             push, pop, load;

   // Memory holds entries not yet moved to the output register
   always_comb begin
      push    = in_valid && in_ready;
      load    = (cnt_r != '0) && (!qv_r || out_ready);
      pop     = qv_r && out_ready;
      wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt  = load ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt = (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(load));
      q_nxt   = load ? mem_r[rp_r] : q_r;
      qv_nxt  = load ? 1'b1 : (pop ? 1'b0 : qv_r);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         q_r   <= '0;
         qv_r  <= 1'b0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
         q_r   <= q_nxt;
         qv_r  <= qv_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Output register counts toward depth, so at most DEPTH words are held
   assign in_ready  = ((cnt_r + (AW+1)'(qv_r)) != (AW+1)'(DEPTH));
   assign out_data  = q_r;
   assign out_valid = qv_r;
endmodule : ssp_fifo
`default_nettype wire

// file: design/ssp_port.sv
// Serial peripheral port: master/slave shifter, select modes, Wishbone registers
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ssp_port (
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [ssp_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      sck_i,
   output logic                           sck_o,
   output logic                           sck_oe,
   input  wire logic                      mosi_i,
   output logic                           mosi_o,
   output logic                           mosi_oe,
   input  wire logic                      miso_i,
   output logic                           miso_o,
   output logic                           miso_oe,
   input  wire logic                      sel_n_i,
   output logic                           sel_n_o,
   output logic                           sel_n_oe
);
   import ssp_pkg::*;

   // Input synchronisers: stage 1 read only by stage 2
   logic [3:0] s1_r, s2_r, s3_r;
   logic       sck_s, mosi_s, miso_s, seln_s, sck_prev, seln_prev;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_r <= SYNC_RESET;
         s2_r <= SYNC_RESET;
         s3_r <= SYNC_RESET;
      end else begin
         s1_r <= {sck_i, mosi_i, miso_i, sel_n_i};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign {sck_s, mosi_s, miso_s, seln_s} = s2_r;
   assign sck_prev  = s3_r[3];
   assign seln_prev = s3_r[0];

   // Control and status state
   ssp_ctrl_s   ctrl_r, ctrl_nxt;
   logic        modf_r, modf_nxt, ovr_r, ovr_nxt;
   logic        ack_r, ack_nxt;
   logic [31:0] rdat_r, rdat_nxt;

   // Shifter state
   ssp_mstate_e         st_r, st_nxt;
   logic [WORD_W-1:0]   sh_r, sh_nxt;
   logic [BIT_CNT_W-1:0] bit_r, bit_nxt;
   logic [DIV_W-1:0]    div_r, div_nxt;
   logic                sck_r, sck_nxt, smp_r, smp_nxt;
   logic                sbusy_r, sbusy_nxt;
   logic [WORD_W-1:0]   rx_r, rx_nxt;
   logic                rxv_r, rxv_nxt;

   // FIFO between bus writes and shifter
   logic              tx_ready, tx_valid, tx_take, tx_push;
   logic [WORD_W-1:0] tx_data;

   ssp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_txfifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_data   (wb_dat_i[WORD_W-1:0]),
      .in_valid  (tx_push),
      .in_ready  (tx_ready),
      .out_data  (tx_data),
      .out_valid (tx_valid),
      .out_ready (tx_take)
   );

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic req, wr, rd_rx, three_wire, selected, sck_edge_lead, sck_edge_trail, master_on;
   always_comb begin
      req        = wb_cyc_i && wb_stb_i && !ack_r;
      wr         = req && wb_we_i;
      three_wire = (ctrl_r.select_pin_mode == SEL_3WIRE);
      selected   = three_wire || (ctrl_r.select_pin_mode == SEL_4W_IN && !seln_s);
      master_on  = ctrl_r.enable && ctrl_r.master;
      sck_edge_lead  = sck_s && !sck_prev;
      sck_edge_trail = !sck_s && sck_prev;
      tx_push    = wr && hit(wb_adr_i, OFS_TXDATA) && wb_sel_i[0];
      rd_rx      = req && !wb_we_i && hit(wb_adr_i, OFS_RXDATA);
   end

   // Register bus: answers every access one cycle after it is taken
   always_comb begin
      ctrl_nxt = ctrl_r;
      modf_nxt = modf_r;
      ack_nxt  = req;
      rdat_nxt = rdat_r;
      if (wr && hit(wb_adr_i, OFS_CTRL)) begin
         if (wb_sel_i[0]) begin
            ctrl_nxt.enable          = wb_dat_i[CTRL_EN];
            ctrl_nxt.master          = wb_dat_i[CTRL_MASTER];
            ctrl_nxt.select_pin_mode = ssp_selmode_e'(wb_dat_i[CTRL_MODE_HI:CTRL_MODE_LO]);
            if (wb_dat_i[CTRL_CLR_MODF]) begin
               modf_nxt = 1'b0;
            end
         end
         if (wb_sel_i[1]) begin
            ctrl_nxt.div = wb_dat_i[CTRL_DIV_LSB +: DIV_W];
         end
      end
      // Select falling edge in four-line input mode ends mastership; set wins over clear
      if (ctrl_r.master && ctrl_r.select_pin_mode == SEL_4W_IN && seln_prev && !seln_s) begin
         ctrl_nxt.master = 1'b0;
         modf_nxt        = 1'b1;
      end
      if (req && !wb_we_i) begin
         rdat_nxt = '0;
         unique case (1'b1)
            hit(wb_adr_i, OFS_CTRL): begin
               rdat_nxt[CTRL_EN]                      = ctrl_r.enable;
               rdat_nxt[CTRL_MASTER]                  = ctrl_r.master;
               rdat_nxt[CTRL_MODE_HI:CTRL_MODE_LO]    = ctrl_r.select_pin_mode;
               rdat_nxt[CTRL_DIV_LSB +: DIV_W]        = ctrl_r.div;
            end
            hit(wb_adr_i, OFS_STATUS): begin
               rdat_nxt[ST_BUSY]   = (st_r != ST_IDLE) || sbusy_r;
               rdat_nxt[ST_RXVAL]  = rxv_r;
               rdat_nxt[ST_TXFULL] = !tx_ready;
               rdat_nxt[ST_MODF]   = modf_r;
               rdat_nxt[ST_RXOVR]  = ovr_r;
               rdat_nxt[ST_SEL]    = selected;
            end
            hit(wb_adr_i, OFS_RXDATA): rdat_nxt[WORD_W-1:0] = rx_r;
            default: rdat_nxt = '0;
         endcase
      end
   end

   // Shifter: mode 0 timing, sample on leading edge, shift on trailing edge
   always_comb begin
      st_nxt    = st_r;
      sh_nxt    = sh_r;
      bit_nxt   = bit_r;
      div_nxt   = div_r;
      sck_nxt   = sck_r;
      smp_nxt   = smp_r;
      sbusy_nxt = sbusy_r;
      rx_nxt    = rx_r;
      rxv_nxt   = rd_rx ? 1'b0 : rxv_r;
      ovr_nxt   = (wr && hit(wb_adr_i, OFS_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_CLR_MODF]) ? 1'b0 : ovr_r;
      tx_take   = 1'b0;
      if (!ctrl_r.enable) begin
         st_nxt    = ST_IDLE;
         sck_nxt   = 1'b0;
         sbusy_nxt = 1'b0;
         bit_nxt   = '0;
      end else if (ctrl_r.master) begin
         unique case (st_r)
            ST_IDLE: begin
               sck_nxt = 1'b0;
               if (tx_valid) begin
                  tx_take = 1'b1;
                  sh_nxt  = tx_data;
                  bit_nxt = '0;
                  div_nxt = ctrl_r.div;
                  st_nxt  = ST_LEAD;
               end
            end
            ST_LEAD: begin
               if (div_r != '0) begin
                  div_nxt = DIV_W'(div_r - 1'b1);
               end else begin
                  sck_nxt = 1'b1;
                  smp_nxt = miso_s;
                  div_nxt = ctrl_r.div;
                  st_nxt  = ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               if (div_r != '0) begin
                  div_nxt = DIV_W'(div_r - 1'b1);
               end else begin
                  sck_nxt = 1'b0;
                  div_nxt = ctrl_r.div;
                  // MSB first, sampled bit enters at LSB
                  sh_nxt  = {sh_r[WORD_W-2:0], smp_r};
                  bit_nxt = BIT_CNT_W'(bit_r + 1'b1);
                  if (bit_r == LAST_BIT) begin
                     rx_nxt  = {sh_r[WORD_W-2:0], smp_r};
                     ovr_nxt = ovr_nxt || rxv_r;
                     rxv_nxt = 1'b1;
                     st_nxt  = ST_IDLE;
                  end else begin
                     st_nxt  = ST_LEAD;
                  end
               end
            end
            default: st_nxt = ST_IDLE;
         endcase
      end else begin
         st_nxt  = ST_IDLE;
         sck_nxt = 1'b0;
         if (!selected) begin
            bit_nxt   = '0;
            sbusy_nxt = 1'b0;
         end else begin
            if (!sbusy_r && tx_valid) begin
               tx_take = 1'b1;
               sh_nxt  = tx_data;
            end
            if (sck_edge_lead) begin
               smp_nxt   = mosi_s;
               sbusy_nxt = 1'b1;
            end else if (sck_edge_trail && sbusy_r) begin
               sh_nxt  = {sh_r[WORD_W-2:0], smp_r};
               bit_nxt = BIT_CNT_W'(bit_r + 1'b1);
               if (bit_r == LAST_BIT) begin
                  rx_nxt    = {sh_r[WORD_W-2:0], smp_r};
                  ovr_nxt   = ovr_nxt || rxv_r;
                  rxv_nxt   = 1'b1;
                  sbusy_nxt = 1'b0;
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_r  <= '{enable: 1'b0, master: 1'b0, select_pin_mode: SEL_4W_IN, div: DIV_RESET};
         modf_r  <= 1'b0;
         ovr_r   <= 1'b0;
         ack_r   <= 1'b0;
         rdat_r  <= '0;
         st_r    <= ST_IDLE;
         sh_r    <= '0;
         bit_r   <= '0;
         div_r   <= '0;
         sck_r   <= 1'b0;
         smp_r   <= 1'b0;
         sbusy_r <= 1'b0;
         rx_r    <= '0;
         rxv_r   <= 1'b0;
      end else begin
         ctrl_r  <= ctrl_nxt;
         modf_r  <= modf_nxt;
         ovr_r   <= ovr_nxt;
         ack_r   <= ack_nxt;
         rdat_r  <= rdat_nxt;
         st_r    <= st_nxt;
         sh_r    <= sh_nxt;
         bit_r   <= bit_nxt;
         div_r   <= div_nxt;
         sck_r   <= sck_nxt;
         smp_r   <= smp_nxt;
         sbusy_r <= sbusy_nxt;
         rx_r    <= rx_nxt;
         rxv_r   <= rxv_nxt;
      end
   end

   // Pin drivers, all registered
   ssp_pin_s sck_p_r, sck_p_nxt, mosi_p_r, mosi_p_nxt, miso_p_r, miso_p_nxt, sel_p_r, sel_p_nxt;
   always_comb begin
      // Clock driven only as enabled master
      sck_p_nxt  = '{o: sck_nxt, oe: ctrl_nxt.enable && ctrl_nxt.master};
      // Master drives MSB on master-to-slave line
      mosi_p_nxt = '{o: sh_nxt[WORD_W-1], oe: ctrl_nxt.enable && ctrl_nxt.master};
      // Slave drives MSB unless disabled or unselected
      miso_p_nxt = '{o: sh_nxt[WORD_W-1], oe: ctrl_nxt.enable && !ctrl_nxt.master && selected};
      // Select driven at low mode bit; never routed in three-line mode
      sel_p_nxt  = '{o: ctrl_nxt.select_pin_mode[0],
                     oe: ctrl_nxt.enable && ctrl_nxt.select_pin_mode[1]};
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sck_p_r  <= '{o: 1'b0, oe: 1'b0};
         mosi_p_r <= '{o: 1'b0, oe: 1'b0};
         miso_p_r <= '{o: 1'b0, oe: 1'b0};
         sel_p_r  <= '{o: 1'b1, oe: 1'b0};
      end else begin
         sck_p_r  <= sck_p_nxt;
         mosi_p_r <= mosi_p_nxt;
         miso_p_r <= miso_p_nxt;
         sel_p_r  <= sel_p_nxt;
      end
   end

   assign {sck_o, sck_oe}     = sck_p_r;
   assign {mosi_o, mosi_oe}   = mosi_p_r;
   assign {miso_o, miso_oe}   = miso_p_r;
   assign {sel_n_o, sel_n_oe} = sel_p_r;
   assign wb_ack_o            = ack_r;
   assign wb_dat_o            = rdat_r;
endmodule : ssp_port
`default_nettype wire

// file: dv/ssp_far_end.sv
// Far-side partner: slave to a master port, master to a slave port
`timescale 1ns/1ps
`default_nettype none
module ssp_far_end (
   input  wire logic sck_w,
   input  wire logic mosi_w,
   input  wire logic miso_w,
   output logic      m_sck,
   output logic      m_mosi,
   output logic      m_miso,
   output logic      m_sel_n
);
   logic [7:0] s_tx;
   logic [7:0] sh_r;
   logic [7:0] rx_r;
   int         cnt;
   logic [7:0] rxq[$];
   initial begin
      m_sck = 1'b0;
      m_mosi = 1'b0;
      m_sel_n = 1'b1;
      sh_r = 8'h00;
      cnt = 0;
   end
   assign m_miso = sh_r[7];
   always @(posedge sck_w) begin
      rx_r = {rx_r[6:0], mosi_w};
      cnt = cnt + 1;
      if (cnt == 8) begin
         rxq.push_back(rx_r);
         cnt = 0;
      end
   end
   always @(negedge sck_w) sh_r = (cnt == 0) ? s_tx : {sh_r[6:0], ~sh_r[0]};
   task automatic sload(input logic [7:0] v);
      s_tx = v;
      sh_r = v;
      cnt = 0;
   endtask : sload
   task automatic set_sel(input logic v);
      m_sel_n <= v;
   endtask : set_sel
   // master frame, clock still between frames
   task automatic mxfer(input logic [7:0] b, input logic hold_off, output logic [7:0] r);
      // Keep link edges off the sampling clock edge
      #1;
      m_sel_n = hold_off;
      #40;
      for (int i = 7; i >= 0; i--) begin
         m_mosi = b[i];
         #40 m_sck = 1'b1;
         r[i] = miso_w;
         #40 m_sck = 1'b0;
      end
      #40 m_sel_n = 1'b1;
      m_mosi = ~m_mosi;
   endtask : mxfer
endmodule : ssp_far_end
`default_nettype wire

// file: dv/ssp_port_properties.sv
// Port-level assertions for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module ssp_port_properties (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic sck_i,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic mosi_o,
   input wire logic mosi_oe,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic sel_n_o,
   input wire logic sel_n_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_mosi_dir; mosi_oe == sck_oe; endproperty
   a_mosi_dir: assert property (p_mosi_dir) else $error("data and clock enables differ");
   property p_miso_dir; !(miso_oe && mosi_oe); endproperty
   a_miso_dir: assert property (p_miso_dir) else $error("both data lines driven");
   property p_sck_quiet; !sck_oe && !$past(sck_oe) |-> $stable(sck_o); endproperty
   a_sck_quiet: assert property (p_sck_quiet) else $error("clock moves undriven");
   property p_mosi_fall; mosi_oe && $past(mosi_oe) && $changed(mosi_o) |-> !sck_o; endproperty
   a_mosi_fall: assert property (p_mosi_fall) else $error("data out moves with clock high");
   property p_mosi_hold; mosi_oe && $rose(sck_o) |-> $stable(mosi_o); endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("data out moves at sample edge");
   property p_miso_fall; miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck_i; endproperty
   a_miso_fall: assert property (p_miso_fall) else $error("slave data moves with clock high");
   property p_sel_out;
      sel_n_oe && $past(sel_n_oe) && !wb_ack_o && !$past(wb_ack_o) && !$past(wb_ack_o, 2) |-> $stable(sel_n_o);
   endproperty
   a_sel_out: assert property (p_sel_out) else $error("select output moves alone");
   c_master: cover property ($rose(sck_oe));
   c_slave: cover property ($rose(miso_oe));
   c_selout: cover property ($rose(sel_n_oe));
endmodule : ssp_port_properties
bind ssp_port ssp_port_properties u_props (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
   .miso_o(miso_o), .miso_oe(miso_oe), .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe));
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t got %0h exp %0h", $time, g, e); end end
module testbench;
   import ssp_pkg::*;
   logic        clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [3:0]  wb_adr;
   logic [31:0] wb_wd, wb_rd, d;
   logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_n_o, sel_n_oe;
   logic        m_sck, m_mosi, m_miso, m_sel_n, sck_w, mosi_w, miso_w, sel_w;
   logic [7:0]  r;
   int          err_count, num_checks, cyc_cnt;
   assign sck_w = sck_oe ? sck_o : m_sck;
   assign mosi_w = mosi_oe ? mosi_o : m_mosi;
   assign miso_w = miso_oe ? miso_o : m_miso;
   assign sel_w = sel_n_oe ? sel_n_o : m_sel_n;
   ssp_port DUT (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
      .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .sel_n_i(sel_w), .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe));
   ssp_far_end fm (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .m_sck(m_sck), .m_mosi(m_mosi),
      .m_miso(m_miso), .m_sel_n(m_sel_n));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 30000) begin
         err_count++;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] ctl(input logic en, input logic ms, input logic [1:0] m);
      return 32'h0000_0200 | {28'h0, m, ms, en};
   endfunction : ctl
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] wd);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wd <= wd;
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      d = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic wait_rx;
      do begin
         wb(1'b0, OFS_STATUS, 32'h0);
      end while (d[ST_RXVAL] !== 1'b1);
   endtask : wait_rx
   task automatic t_reset;
      `CHK({sck_oe, mosi_oe, miso_oe, sel_n_oe, sel_n_o}, 5'h01)
      wb(1'b0, OFS_CTRL, 32'h0);
      `CHK(d, 32'h0000_0404)
      wb(1'b0, 4'h2, 32'h0);
      `CHK(d, 32'h0)
   endtask : t_reset
   task automatic t_master;
      for (int m = 0; m < 4; m++) begin
         fm.sload(8'h3C + 8'(m));
         fm.rxq.delete();
         wb(1'b1, OFS_TXDATA, 32'hA5 + m);
         wb(1'b1, OFS_CTRL, ctl(1'b1, 1'b1, 2'(m)));
         wait_rx();
         wb(1'b0, OFS_RXDATA, 32'h0);
         `CHK(d[7:0], 8'h3C + 8'(m))
         `CHK(fm.rxq[0], 8'hA5 + 8'(m))
         `CHK({sel_n_oe, miso_oe}, {m[1], 1'b0})
         if (m[1]) `CHK(sel_n_o, m[0])
         wb(1'b1, OFS_CTRL, ctl(1'b0, 1'b1, 2'(m)));
      end
   endtask : t_master
   task automatic t_fifo;
      fm.sload(8'h77);
      fm.rxq.delete();
      for (int i = 0; i < 9; i++) wb(1'b1, OFS_TXDATA, 32'h10 + i);
      wb(1'b0, OFS_STATUS, 32'h0);
      `CHK(d[ST_TXFULL], 1'b1)
      wb(1'b1, OFS_CTRL, ctl(1'b1, 1'b1, 2'b00));
      for (int i = 0; i < 8; i++) begin
         wait_rx();
         wb(1'b0, OFS_RXDATA, 32'h0);
         `CHK(d[7:0], 8'h77)
      end
      repeat (4) @(posedge clk);
      `CHK(fm.rxq.size(), 8)
      for (int i = 0; i < 8; i++) `CHK(fm.rxq[i], 8'h10 + 8'(i))
      wb(1'b1, OFS_CTRL, ctl(1'b0, 1'b1, 2'b00));
   endtask : t_fifo
   task automatic t_fault;
      wb(1'b1, OFS_CTRL, ctl(1'b1, 1'b1, 2'b01));
      fm.set_sel(1'b0);
      repeat (8) @(posedge clk);
      `CHK({sck_oe, mosi_oe}, 2'b00)
      wb(1'b0, OFS_STATUS, 32'h0);
      `CHK(d[ST_MODF], 1'b1)
      fm.set_sel(1'b1);
      wb(1'b1, OFS_CTRL, 32'h0000_0014);
      wb(1'b0, OFS_STATUS, 32'h0);
      `CHK(d[ST_MODF], 1'b0)
   endtask : t_fault
   task automatic t_slave(input logic [1:0] m);
      wb(1'b1, OFS_TXDATA, 32'h96 + {30'h0, m});
      wb(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, m));
      repeat (4) @(posedge clk);
      `CHK(miso_oe, ~m[0])
      if (m[0]) begin
         fm.mxfer(8'hFF, 1'b1, r);
         @(posedge clk);
         wb(1'b0, OFS_STATUS, 32'h0);
         `CHK(d[ST_RXVAL], 1'b0)
      end
      fm.mxfer(8'h5A + 8'(m), 1'b0, r);
      @(posedge clk);
      `CHK(r, 8'h96 + 8'(m))
      wait_rx();
      wb(1'b0, OFS_RXDATA, 32'h0);
      `CHK(d[7:0], 8'h5A + 8'(m))
      repeat (6) @(posedge clk);
      `CHK(miso_oe, ~m[0])
      wb(1'b1, OFS_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      `CHK(miso_oe, 1'b0)
   endtask : t_slave
   initial begin
      nrst = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_wd = 32'h0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_master();
      t_fifo();
      t_fault();
      t_slave(2'b00);
      t_slave(2'b01);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire

// file: include/ssp_pkg.sv
// Package: constants, types and register map for the serial peripheral port
package ssp_pkg;
   localparam int          ADDR_W        = 4;
   localparam int          WORD_W        = 8;
   localparam int          FIFO_DEPTH    = 8;
   localparam int          BIT_CNT_W     = 3;
   localparam int          DIV_W         = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_TXDATA = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_RXDATA = 4'hC;
   localparam logic [DIV_W-1:0]  DIV_RESET  = 8'h04;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
   // Synchroniser idle levels {sck, mosi, miso, sel_n}: clock low, select high
   localparam logic [3:0]        SYNC_RESET = 4'h1;
   // Control register fields
   localparam int CTRL_EN       = 0;
   localparam int CTRL_MASTER   = 1;
   localparam int CTRL_MODE_LO  = 2;
   localparam int CTRL_MODE_HI  = 3;
   localparam int CTRL_CLR_MODF = 4;
   localparam int CTRL_DIV_LSB  = 8;
   // Status register fields
   localparam int ST_BUSY   = 0;
   localparam int ST_RXVAL  = 1;
   localparam int ST_TXFULL = 2;
   localparam int ST_MODF   = 3;
   localparam int ST_RXOVR  = 4;
   localparam int ST_SEL    = 5;

   typedef enum logic [1:0] {
      SEL_3WIRE   = 2'b00,
      SEL_4W_IN   = 2'b01,
      SEL_4W_OUT0 = 2'b10,
      SEL_4W_OUT1 = 2'b11
   } ssp_selmode_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LEAD  = 2'b01,
      ST_TRAIL = 2'b10
   } ssp_mstate_e;

   typedef struct packed {
      logic  enable;
      logic  master;
      ssp_selmode_e select_pin_mode;
      logic [DIV_W-1:0] div;
   } ssp_ctrl_s;

   typedef struct packed {
      logic  o;
      logic  oe;
   } ssp_pin_s;
endpackage : ssp_pkg
